// >>> shared/door_lock_map.svh
// Register offsets, field positions, reset values and timing figures of the door controller
`ifndef DOOR_LOCK_MAP_SVH
`define DOOR_LOCK_MAP_SVH
`define A_CTRL 8'h00
`define A_IN2 8'h04
`define A_REL_TIME 8'h08
`define A_AJAR_TIME 8'h0C
`define A_SIG_TAMPER 8'h10
`define A_SIG_FORCED 8'h14
`define A_SIG_AJAR 8'h18
`define A_SIG_APB 8'h1C
`define A_SIG_CARD 8'h20
`define A_PULSE 8'h24
`define A_STATUS 8'h28
`define A_HOST_OPEN 8'h2C
`define F_FN_LO 0
`define F_FN_HI 1
`define F_POL 2
`define F_BEEP_EN 3
`define F_IN1_EXIT 4
`define F_EXIT_TAMPER 5
`define F_SCHED 6
`define RST_CTRL 8'h28
`define RST_IN2 3'h0
`define RST_REL_TIME 8'h07
`define RST_AJAR_TIME 8'h14
`define RST_SIG_TAMPER 8'h1E
`define RST_SIG_FORCED 8'h1E
`define RST_SIG_AJAR 8'h00
`define RST_SIG_APB 8'h00
`define RST_SIG_CARD 8'h1E
`define RST_PULSE 16'h01F4
`define CLK_PERIOD_NS 20
`define TICK_MS_NS 1000000
`define MS_PER_S 1000
`endif

// >>> shared/door_lock_pkg.sv
// Types shared by the door controller
package door_lock_pkg;
   typedef enum logic [1:0] {FN_STANDARD, FN_TOGGLE, FN_PULSE} lock_fn_t;
   typedef enum logic [2:0] {IN2_EXIT, IN2_HANDLE, IN2_EXT_TAMPER, IN2_TAMPER, IN2_DISABLE} in2_fn_t;
   // Alarm bit order: 0 tamper, 1 forced door, 2 door ajar, 3 pass-back, 4 flagged card
   typedef struct packed {
      logic [15:0] ms_div;
      logic [9:0] sec_div;
      logic ms_tick;
      logic sec_tick;
      logic [7:0] ctrl;
      in2_fn_t in2;
      logic [7:0] rel_time;
      logic [7:0] ajar_time;
      logic [4:0][7:0] sig_time;
      logic [15:0] pulse_ms;
      logic in1_q;
      logic in2_q;
      logic in3_q;
      logic sens_q;
      logic door_armed;
      logic [2:0] tmp_armed;
      logic released;
      logic toggled;
      logic open_beep;
      logic [7:0] rel_cnt;
      logic [15:0] pulse_cnt;
      logic [8:0] ajar_cnt;
      logic [4:0] alarm;
      logic [4:0] alo;
      logic [3:0][7:0] snd_cnt;
      logic blink;
      logic lock;
      logic beeper;
      logic alarm_out;
      logic invalid_id;
      logic [31:0] rdata;
   } state_t;
endpackage : door_lock_pkg

// >>> rtl/door_access_lock_alarm_ctrl.sv
// Door lock, beeper, alarm detection and register port of the access controller
// Notes on behaviour
// - Standard: open releases lock, beeps until open/expiry
// - Valid card while released reloads release timer
// - Toggle: open inverts lock, beep until open/expiry
// - Pulse: lock released for pulse width milliseconds
// - Function standard/toggle/pulse, polarity direct/reverse
// - Open from card, host, exit; exit blocked in alarm
// - Schedule holds release; no forced alarm then
// - Schedule hold and toggle never together
// - First and second input function selectable
// - Tamper on sensor/input change, armed after first change
// - Forced door unless opened or handle active
// - Door ajar after open longer than timeout
// - Pass-back alarm when counter runs or zone blocks
// - Flagged card raises card alarm
// - Report all; beeper and output per alarm type
// - Tamper steady tone, forced/ajar/pass-back intermittent, flagged card silent
// - Alarm sound ends on card or time
// - Alarm output on timed alarms except pass-back, off when all clear
// - Card never clears alarms; valid silences, opens unless pass-back
// - Invalid card silences and flags, never opens
// - Exit during tamper allowed by setting
// - Signalling times 0..255 s, tamper default 30
// - Door contact ignored until first change
//
// Added by the designer: the address map and the strobed register port.
`include "door_lock_map.svh"
module door_access_lock_alarm_ctrl #(
   parameter logic [15:0] MS_CYCLES = 16'(`TICK_MS_NS / `CLK_PERIOD_NS)
) (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESET_I,
   // Register port
   input wire logic [7:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   // Card decoder events
   input wire logic ID_VALID_I,
   input wire logic ID_INVALID_I,
   input wire logic ID_ALARM_FLAG_I,
   input wire logic APB_TIME_RUN_I,
   input wire logic APB_ZONE_BLOCK_I,
   // Contacts and schedule
   input wire logic FIRST_INPUT_I,
   input wire logic SECOND_INPUT_I,
   input wire logic THIRD_INPUT_I,
   input wire logic TAMPER_SENSOR_I,
   input wire logic SCHEDULE_VALID_I,
   // Door and alarm outputs
   output logic LOCK_O,
   output logic BEEPER_O,
   output logic ALARM_O,
   output logic [4:0] ALARM_STATE_O,
   output logic INVALID_ID_O
);
   localparam logic [9:0] SEC_MS = 10'(`MS_PER_S - 1);
   localparam logic [4:0] OUT_MASK = 5'h17;

   door_lock_pkg::state_t s;
   door_lock_pkg::state_t next_s;

   always_comb begin
      door_lock_pkg::lock_fn_t fn;
      door_lock_pkg::lock_fn_t wfn;
      logic door_cfg;
      logic door_open;
      logic door_edge;
      logic ex_now;
      logic ex_prev;
      logic exit_ok;
      logic host_open;
      logic apb;
      logic open_req;
      logic hold;
      logic active;
      logic handle;
      logic card;
      logic [2:0] chg;
      logic [2:0] tsrc;
      logic [4:0] ev;
      logic [4:0] clr;
      fn = door_lock_pkg::lock_fn_t'(s.ctrl[`F_FN_HI:`F_FN_LO]);
      wfn = door_lock_pkg::lock_fn_t'(WDATA_I[`F_FN_HI:`F_FN_LO]);
      next_s = s;
      next_s.ms_tick = 1'b0;
      next_s.sec_tick = 1'b0;
      next_s.invalid_id = ID_INVALID_I;
      if (s.ms_div == MS_CYCLES - 16'h0001) begin
         next_s.ms_div = 16'h0000;
         next_s.ms_tick = 1'b1;
         if (s.sec_div == SEC_MS) begin
            next_s.sec_div = 10'h000;
            next_s.sec_tick = 1'b1;
         end else begin
            next_s.sec_div = s.sec_div + 10'h001;
         end
      end else begin
         next_s.ms_div = s.ms_div + 16'h0001;
      end
      next_s.in1_q = FIRST_INPUT_I;
      next_s.in2_q = SECOND_INPUT_I;
      next_s.in3_q = THIRD_INPUT_I;
      next_s.sens_q = TAMPER_SENSOR_I;
      // first input as door contact, closed when high
      door_cfg = !s.ctrl[`F_IN1_EXIT];
      // door contact armed by its first change
      if (door_cfg && FIRST_INPUT_I != s.in1_q) begin
         next_s.door_armed = 1'b1;
      end
      door_open = door_cfg && s.door_armed && !FIRST_INPUT_I;
      door_edge = door_open && s.in1_q;
      ex_now = (s.ctrl[`F_IN1_EXIT] && FIRST_INPUT_I) || (s.in2 == door_lock_pkg::IN2_EXIT && SECOND_INPUT_I);
      ex_prev = (s.ctrl[`F_IN1_EXIT] && s.in1_q) || (s.in2 == door_lock_pkg::IN2_EXIT && s.in2_q);
      // exit only without alarm, tamper by setting
      exit_ok = s.alarm[4:1] == 4'h0 && (!s.alarm[0] || s.ctrl[`F_EXIT_TAMPER]);
      host_open = WR_I && ADDR_I == `A_HOST_OPEN && WDATA_I[0];
      apb = ID_VALID_I && (APB_TIME_RUN_I || APB_ZONE_BLOCK_I);
      // open sources; invalid card never opens
      open_req = (ID_VALID_I && !apb) || host_open || (ex_now && !ex_prev && exit_ok);
      hold = s.ctrl[`F_SCHED] && SCHEDULE_VALID_I && fn != door_lock_pkg::FN_TOGGLE;
      active = hold || s.released || (fn == door_lock_pkg::FN_TOGGLE && s.toggled);
      handle = s.in2 == door_lock_pkg::IN2_HANDLE && SECOND_INPUT_I;
      case (fn)
         door_lock_pkg::FN_STANDARD: begin
            // release with reload on each request
            if (open_req) begin
               next_s.released = 1'b1;
               next_s.rel_cnt = s.rel_time;
               next_s.open_beep = s.ctrl[`F_BEEP_EN];
            end else if (s.released && (door_edge || (s.sec_tick && s.rel_cnt <= 8'h01))) begin
               next_s.released = 1'b0;
               next_s.open_beep = 1'b0;
            end else if (s.released && s.sec_tick) begin
               next_s.rel_cnt = s.rel_cnt - 8'h01;
            end
         end
         door_lock_pkg::FN_TOGGLE: begin
            // invert lock, beep on release timer
            if (open_req) begin
               next_s.toggled = !s.toggled;
               next_s.rel_cnt = s.rel_time;
               next_s.open_beep = s.ctrl[`F_BEEP_EN];
            end else if (s.open_beep && (door_edge || (s.sec_tick && s.rel_cnt <= 8'h01))) begin
               next_s.open_beep = 1'b0;
            end else if (s.open_beep && s.sec_tick) begin
               next_s.rel_cnt = s.rel_cnt - 8'h01;
            end
         end
         door_lock_pkg::FN_PULSE: begin
            if (open_req) begin
               next_s.released = 1'b1;
               next_s.pulse_cnt = s.pulse_ms;
            end else if (s.released && s.ms_tick) begin
               if (s.pulse_cnt <= 16'h0001) begin
                  next_s.released = 1'b0;
               end else begin
                  next_s.pulse_cnt = s.pulse_cnt - 16'h0001;
               end
            end
         end
         default: begin
            next_s.released = 1'b0;
         end
      endcase
      // tamper sources armed by their first change
      tsrc[0] = s.in2 == door_lock_pkg::IN2_TAMPER || s.in2 == door_lock_pkg::IN2_EXT_TAMPER;
      tsrc[1] = 1'b1;
      tsrc[2] = 1'b1;
      chg[0] = tsrc[0] && SECOND_INPUT_I != s.in2_q;
      chg[1] = THIRD_INPUT_I != s.in3_q;
      chg[2] = TAMPER_SENSOR_I != s.sens_q;
      next_s.tmp_armed = s.tmp_armed | chg;
      ev[0] = |(chg & s.tmp_armed);
      ev[1] = door_edge && !active && !handle;
      if (!door_open) begin
         next_s.ajar_cnt = 9'h000;
      end else if (s.sec_tick && s.ajar_cnt != 9'h1FF) begin
         next_s.ajar_cnt = s.ajar_cnt + 9'h001;
      end
      ev[2] = door_open && s.ajar_cnt > {1'b0, s.ajar_time} && !s.alarm[2];
      ev[3] = apb;
      card = ID_VALID_I || ID_INVALID_I;
      ev[4] = card && ID_ALARM_FLAG_I;
      clr = (WR_I && ADDR_I == `A_STATUS) ? WDATA_I[4:0] : 5'h00;
      // cards never clear alarms; event wins over clear
      for (int i = 0; i < 5; i++) begin
         if (i == 1 || i == 2) begin
            next_s.alarm[i] = (s.alarm[i] && door_open) || ev[i];
         end else begin
            next_s.alarm[i] = (s.alarm[i] && !clr[i]) || ev[i];
         end
         // output only for timed alarms of output types
         next_s.alo[i] = OUT_MASK[i] && ((s.alo[i] && next_s.alarm[i]) || (ev[i] && s.sig_time[i] != 8'h00));
      end
      // output holds until all alarms clear
      next_s.alarm_out = |next_s.alo || (s.alarm_out && |next_s.alarm);
      // sound timers, silenced by any card
      for (int i = 0; i < 4; i++) begin
         if (ev[i]) begin
            next_s.snd_cnt[i] = s.sig_time[i];
         end else if (card) begin
            next_s.snd_cnt[i] = 8'h00;
         end else if (s.sec_tick && s.snd_cnt[i] != 8'h00) begin
            next_s.snd_cnt[i] = s.snd_cnt[i] - 8'h01;
         end
      end
      if (s.sec_tick) begin
         next_s.blink = !s.blink;
      end
      if (s.snd_cnt[0] != 8'h00) begin
         next_s.beeper = 1'b1;
      end else if (s.snd_cnt[3:1] != 24'h000000) begin
         next_s.beeper = s.blink;
      end else begin
         next_s.beeper = s.open_beep;
      end
      // Register writes
      if (WR_I) begin
         case (ADDR_I)
            `A_CTRL: begin
               // refuse toggle with schedule and the unused code
               if (!(wfn == door_lock_pkg::FN_TOGGLE && WDATA_I[`F_SCHED]) && WDATA_I[`F_FN_HI:`F_FN_LO] != 2'h3) begin
                  next_s.ctrl = WDATA_I[7:0];
                  // Any accepted control write drops a pending release to avoid a stuck lock
                  next_s.released = 1'b0;
                  next_s.toggled = 1'b0;
                  next_s.open_beep = 1'b0;
               end
            end
            `A_IN2: begin
               if (WDATA_I[2:0] <= 3'h4) begin
                  next_s.in2 = door_lock_pkg::in2_fn_t'(WDATA_I[2:0]);
               end
            end
            `A_REL_TIME: next_s.rel_time = WDATA_I[7:0];
            `A_AJAR_TIME: next_s.ajar_time = WDATA_I[7:0];
            `A_SIG_TAMPER: next_s.sig_time[0] = WDATA_I[7:0];
            `A_SIG_FORCED: next_s.sig_time[1] = WDATA_I[7:0];
            `A_SIG_AJAR: next_s.sig_time[2] = WDATA_I[7:0];
            `A_SIG_APB: next_s.sig_time[3] = WDATA_I[7:0];
            `A_SIG_CARD: next_s.sig_time[4] = WDATA_I[7:0];
            `A_PULSE: next_s.pulse_ms = WDATA_I[15:0];
            default: begin
            end
         endcase
      end
      // polarity applied to the effective release
      next_s.lock = (hold || (fn == door_lock_pkg::FN_TOGGLE ? next_s.toggled : next_s.released)) ^ s.ctrl[`F_POL];
      next_s.rdata = 32'h00000000;
      if (RD_I) begin
         case (ADDR_I)
            `A_CTRL: next_s.rdata = {24'h000000, s.ctrl};
            `A_IN2: next_s.rdata = {29'h00000000, s.in2};
            `A_REL_TIME: next_s.rdata = {24'h000000, s.rel_time};
            `A_AJAR_TIME: next_s.rdata = {24'h000000, s.ajar_time};
            `A_SIG_TAMPER: next_s.rdata = {24'h000000, s.sig_time[0]};
            `A_SIG_FORCED: next_s.rdata = {24'h000000, s.sig_time[1]};
            `A_SIG_AJAR: next_s.rdata = {24'h000000, s.sig_time[2]};
            `A_SIG_APB: next_s.rdata = {24'h000000, s.sig_time[3]};
            `A_SIG_CARD: next_s.rdata = {24'h000000, s.sig_time[4]};
            `A_PULSE: next_s.rdata = {16'h0000, s.pulse_ms};
            `A_STATUS: next_s.rdata = {22'h000000, hold, s.door_armed, s.alarm_out, s.beeper, s.lock, s.alarm};
            default: next_s.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         s <= '0;
         s.ctrl <= `RST_CTRL;
         s.in2 <= door_lock_pkg::in2_fn_t'(`RST_IN2);
         s.rel_time <= `RST_REL_TIME;
         s.ajar_time <= `RST_AJAR_TIME;
         s.sig_time <= {`RST_SIG_CARD, `RST_SIG_APB, `RST_SIG_AJAR, `RST_SIG_FORCED, `RST_SIG_TAMPER};
         s.pulse_ms <= `RST_PULSE;
         // Door contact starts as closed so power-up level is no event
         s.in1_q <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign RDATA_O = s.rdata;
   assign LOCK_O = s.lock;
   assign BEEPER_O = s.beeper;
   assign ALARM_O = s.alarm_out;
   assign ALARM_STATE_O = s.alarm;
   assign INVALID_ID_O = s.invalid_id;
endmodule : door_access_lock_alarm_ctrl

// >>> sim/door_lock_checker_asserts.sv
// Port checks of the door controller
`include "door_lock_map.svh"
module door_lock_checker (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESET_I,
   // Watched ports
   input wire logic [7:0] ADDR_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [31:0] RDATA_O,
   input wire logic ID_VALID_I,
   input wire logic ID_INVALID_I,
   input wire logic ID_ALARM_FLAG_I,
   input wire logic APB_TIME_RUN_I,
   input wire logic APB_ZONE_BLOCK_I,
   input wire logic ALARM_O,
   input wire logic [4:0] ALARM_STATE_O,
   input wire logic INVALID_ID_O
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RESET_I);
   a_invalid_flag:
   assert property (ID_INVALID_I |=> INVALID_ID_O) else $error("invalid card not flagged");
   a_invalid_cause:
   assert property (INVALID_ID_O |-> $past(ID_INVALID_I)) else $error("invalid flag without card");
   a_flag_alarm:
   assert property ((ID_VALID_I || ID_INVALID_I) && ID_ALARM_FLAG_I |=> ALARM_STATE_O[4])
      else $error("flagged card alarm missing");
   a_apb_alarm:
   assert property (ID_VALID_I && (APB_TIME_RUN_I || APB_ZONE_BLOCK_I) |=> ALARM_STATE_O[3])
      else $error("pass-back alarm missing");
   a_card_keeps_alarm:
   assert property ((ID_VALID_I || ID_INVALID_I) && !WR_I
      |=> (ALARM_STATE_O & $past(ALARM_STATE_O) & 5'h19) == ($past(ALARM_STATE_O) & 5'h19))
      else $error("card cleared an alarm");
   a_out_fall:
   assert property ($fell(ALARM_O) |-> ALARM_STATE_O == 5'h00) else $error("alarm output dropped early");
   a_out_cause:
   assert property ($rose(ALARM_O) |-> |(ALARM_STATE_O & 5'h17)) else $error("alarm output without cause");
   a_time_narrow:
   assert property (RD_I && ADDR_I == `A_SIG_TAMPER |=> RDATA_O[31:8] == 24'h000000)
      else $error("signal time wider than 8 bits");
endmodule : door_lock_checker

bind door_access_lock_alarm_ctrl door_lock_checker door_lock_checker_i (
   .REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WR_I(WR_I), .RD_I(RD_I),
   .RDATA_O(RDATA_O), .ID_VALID_I(ID_VALID_I), .ID_INVALID_I(ID_INVALID_I),
   .ID_ALARM_FLAG_I(ID_ALARM_FLAG_I), .APB_TIME_RUN_I(APB_TIME_RUN_I),
   .APB_ZONE_BLOCK_I(APB_ZONE_BLOCK_I), .ALARM_O(ALARM_O), .ALARM_STATE_O(ALARM_STATE_O),
   .INVALID_ID_O(INVALID_ID_O));

// >>> sim/door_field_model.sv
// Door leaf with its contact, as seen at the first input
module door_field_model (
   input wire logic clk_i,
   input wire logic push_i,
   output logic contact_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial contact_o = 1'b1;
   always @(posedge clk_i) begin
      contact_o <= !push_i;
   end
endmodule : door_field_model

// >>> sim/door_access_lock_alarm_ctrl_tb_top.sv
// Self-checking bench of the door controller
`include "door_lock_map.svh"
module door_access_lock_alarm_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SEC = 4000;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic idv = 1'b0, idi = 1'b0, flag = 1'b0, apbt = 1'b0, apbz = 1'b0, sec = 1'b0;
   logic third = 1'b0, tamp = 1'b0, sched = 1'b0, push = 1'b0, first;
   logic lock, beep, alarm, inv;
   logic [4:0] state;
   int fails = 0, checks = 0, cyc = 0;
   logic [31:0] dflt [11] = '{32'h28, 32'h0, 32'h7, 32'h14, 32'h1E, 32'h1E, 32'h0, 32'h0, 32'h1E, 32'h1F4, 32'h0};
   door_access_lock_alarm_ctrl #(.MS_CYCLES(16'h0004)) door_access_lock_alarm_ctrl_i (
      .REF_CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .ID_VALID_I(idv), .ID_INVALID_I(idi), .ID_ALARM_FLAG_I(flag),
      .APB_TIME_RUN_I(apbt), .APB_ZONE_BLOCK_I(apbz), .FIRST_INPUT_I(first), .SECOND_INPUT_I(sec),
      .THIRD_INPUT_I(third), .TAMPER_SENSOR_I(tamp), .SCHEDULE_VALID_I(sched), .LOCK_O(lock),
      .BEEPER_O(beep), .ALARM_O(alarm), .ALARM_STATE_O(state), .INVALID_ID_O(inv));
   door_field_model door_field_model_i (.clk_i(clk), .push_i(push), .contact_o(first));
   initial begin
      forever #10 clk = !clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   // Hang guard, well above the longest path
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         fails++;
         tally_and_finish();
      end
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : idle
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk) wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk) addr <= a;
      rd <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      @(negedge clk);
      chk($sformatf("reg %h", a), rdata, exp);
   endtask : rd_reg
   // Card event, ends in the cycle after it for checks
   task automatic card(input logic ok, input logic f);
      @(posedge clk) idv <= ok;
      idi <= !ok;
      flag <= f;
      @(posedge clk) idv <= 1'b0;
      idi <= 1'b0;
      flag <= 1'b0;
      @(negedge clk);
   endtask : card
   task automatic wait_lock(input logic v, input int max);
      int n;
      n = 0;
      while (lock !== v && n < max) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_lock
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      foreach (dflt[i]) rd_reg(8'(4 * i), dflt[i]);
      rd_reg(8'h30, 32'h0);
      // Door contact stays ignored until its first change, so arm it first
      @(posedge clk) push <= 1'b1;
      idle(3);
      @(posedge clk) push <= 1'b0;
      idle(3);
      rd_reg(`A_STATUS, 32'h100);
      wr_reg(`A_REL_TIME, 32'h2);
      wr_reg(`A_PULSE, 32'h2);
      card(1'b1, 1'b0);
      chk("lock", lock, 32'h1);
      // Beeper follows the release one cycle later
      idle(1);
      chk("beeper", beep, 32'h1);
      wait_lock(1'b0, 3 * SEC);
      idle(1);
      chk("beeper", beep, 32'h0);
      // Lock now dropped on a second tick, so reload shows
      card(1'b1, 1'b0);
      idle(SEC * 3 / 2);
      card(1'b1, 1'b0);
      idle(SEC);
      chk("lock", lock, 32'h1);
      @(posedge clk) push <= 1'b1;
      idle(3);
      chk("lock", lock, 32'h0);
      @(posedge clk) push <= 1'b0;
      idle(3);
      @(posedge clk) push <= 1'b1;
      idle(3);
      chk("state", state, 32'h2);
      chk("alarm", alarm, 32'h1);
      @(posedge clk) push <= 1'b0;
      idle(3);
      chk("alarm", alarm, 32'h0);
      wr_reg(`A_AJAR_TIME, 32'h1);
      card(1'b1, 1'b0);
      @(posedge clk) push <= 1'b1;
      idle(3 * SEC);
      chk("state", state, 32'h4);
      chk("alarm", alarm, 32'h0);
      @(posedge clk) push <= 1'b0;
      @(posedge clk) tamp <= 1'b1;
      idle(3);
      chk("state", state, 32'h0);
      @(posedge clk) tamp <= 1'b0;
      idle(SEC);
      chk("state", state, 32'h1);
      chk("beeper", beep, 32'h1);
      card(1'b0, 1'b0);
      chk("invalid", inv, 32'h1);
      idle(2);
      chk("beeper", beep, 32'h0);
      chk("lock", lock, 32'h0);
      card(1'b1, 1'b0);
      chk("lock", lock, 32'h1);
      chk("state", state, 32'h1);
      wait_lock(1'b0, 3 * SEC);
      @(posedge clk) sec <= 1'b1;
      idle(2);
      chk("lock", lock, 32'h1);
      @(posedge clk) sec <= 1'b0;
      wait_lock(1'b0, 3 * SEC);
      wr_reg(`A_CTRL, 32'h8);
      @(posedge clk) sec <= 1'b1;
      idle(2);
      chk("lock", lock, 32'h0);
      @(posedge clk) sec <= 1'b0;
      wr_reg(`A_CTRL, 32'h28);
      wr_reg(`A_STATUS, 32'h1F);
      idle(2);
      chk("alarm", alarm, 32'h0);
      card(1'b1, 1'b1);
      chk("state", state, 32'h10);
      chk("alarm", alarm, 32'h1);
      wr_reg(`A_STATUS, 32'h10);
      wait_lock(1'b0, 3 * SEC);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk) apbt <= (i == 0);
         apbz <= (i == 1);
         card(1'b1, 1'b0);
         chk("state", state, 32'h8);
         chk("lock", lock, 32'h0);
         chk("alarm", alarm, 32'h0);
         @(posedge clk) apbt <= 1'b0;
         apbz <= 1'b0;
         wr_reg(`A_STATUS, 32'h8);
      end
      wr_reg(`A_CTRL, 32'h29);
      wr_reg(`A_HOST_OPEN, 32'h1);
      idle(2);
      chk("lock", lock, 32'h1);
      chk("beeper", beep, 32'h1);
      wr_reg(`A_HOST_OPEN, 32'h1);
      idle(2);
      chk("lock", lock, 32'h0);
      wr_reg(`A_CTRL, 32'h69);
      rd_reg(`A_CTRL, 32'h29);
      wr_reg(`A_CTRL, 32'h2A);
      wr_reg(`A_HOST_OPEN, 32'h1);
      idle(2);
      chk("lock", lock, 32'h1);
      idle(20);
      chk("lock", lock, 32'h0);
      wr_reg(`A_CTRL, 32'h2C);
      idle(2);
      chk("lock", lock, 32'h1);
      wr_reg(`A_CTRL, 32'h68);
      @(posedge clk) sched <= 1'b1;
      idle(3);
      chk("lock", lock, 32'h1);
      @(posedge clk) push <= 1'b1;
      idle(3);
      chk("state", state, 32'h0);
      @(posedge clk) push <= 1'b0;
      sched <= 1'b0;
      idle(3);
      chk("lock", lock, 32'h0);
      tally_and_finish();
   end
endmodule : door_access_lock_alarm_ctrl_tb_top
